// ---- ovc_setpoint_ctrl.sv ----
// Output set-point control: limits, trim, margins, boot strap decode and set-point reset
`timescale 1ns/1ps
`include "ovc_regs_map.svh"

module ovc_setpoint_ctrl #(
  parameter int SLEW_CYC   = 40,
  parameter int STRAP_GAP  = 64
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_lnk_clk,
  input  wire logic        i_lnk_wr,
  input  wire logic        i_lnk_rd,
  input  wire logic [7:0]  i_lnk_cmd,
  input  wire logic [15:0] i_lnk_wdata,
  input  wire logic [3:0]  i_strap_code,
  input  wire logic        i_setpoint_reset_pin_n,
  input  wire logic [11:0] i_nvm_setpoint,
  input  wire logic        i_fault_restart,
  input  wire logic [10:0] i_freq_req_khz,
  output logic [15:0]      o_lnk_rdata,
  output logic             o_lnk_rvalid,
  output logic             o_lnk_busy,
  output logic [11:0]      o_ref_code,
  output logic             o_master_en,
  output logic             o_alert_o,
  output logic             o_alert_oe,
  output logic             o_boot_done,
  output logic [10:0]      o_sw_freq_khz
);

  // ***************************************************************
  // Constants and helpers
  // ***************************************************************
  localparam int RST_RESP_CYC = `OVC_RST_RESP_NS / `OVC_CLK_NS;
  localparam logic [15:0] RST_KICK = 16'(RST_RESP_CYC - 4);
  localparam logic [15:0] SLEW_RLD = 16'(SLEW_CYC - 1);
  localparam logic [15:0] GAP_RLD  = 16'(STRAP_GAP - 1);

  // Window low edge for a scale
  function automatic logic [11:0] win_lo(input logic [15:0] s);
    win_lo = (s == `OVC_SCL_HALF) ? `OVC_W2_LO : (s == `OVC_SCL_QTR) ? `OVC_W4_LO : `OVC_W1_LO;
  endfunction

  // Window high edge for a scale
  function automatic logic [11:0] win_hi(input logic [15:0] s);
    win_hi = (s == `OVC_SCL_HALF) ? `OVC_W2_HI : (s == `OVC_SCL_QTR) ? `OVC_W4_HI : `OVC_W1_HI;
  endfunction

  // Clamp a signed byte into a range
  function automatic logic signed [7:0] clip8(input logic signed [7:0] v,
                                              input logic signed [7:0] lo,
                                              input logic signed [7:0] hi);
    clip8 = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // ***************************************************************
  // Link domain: capture requests, toggle towards the core
  // ***************************************************************
  ovc_pkg::ovc_req_t lnk_req_reg;
  logic              lnk_wtog_reg;
  logic              lnk_rtog_reg;
  logic              lnk_wack_s1_reg, lnk_wack_s2_reg;
  logic              lnk_rack_s1_reg, lnk_rack_s2_reg, lnk_rack_s3_reg;
  logic              sys_wack_reg, sys_rack_reg;
  logic [15:0]       sys_rdata_reg;

  wire lnk_pending = (lnk_wtog_reg != lnk_wack_s2_reg) || (lnk_rtog_reg != lnk_rack_s3_reg);
  wire lnk_take    = (i_lnk_wr || i_lnk_rd) && !lnk_pending;
  wire lnk_rdone   = lnk_rack_s2_reg != lnk_rack_s3_reg;

  // Request word is held until the core acknowledges, so it crosses stable
  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk_req_reg  <= '0;
      lnk_wtog_reg <= 1'b0;
      lnk_rtog_reg <= 1'b0;
    end else if (lnk_take) begin
      lnk_req_reg  <= '{cmd: i_lnk_cmd, data: i_lnk_wdata};
      lnk_wtog_reg <= lnk_wtog_reg ^ i_lnk_wr;
      lnk_rtog_reg <= lnk_rtog_reg ^ (i_lnk_rd && !i_lnk_wr);
    end
  end

  // Acknowledge synchronisers and read return
  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk_wack_s1_reg <= 1'b0;
      lnk_wack_s2_reg <= 1'b0;
      lnk_rack_s1_reg <= 1'b0;
      lnk_rack_s2_reg <= 1'b0;
      lnk_rack_s3_reg <= 1'b0;
      o_lnk_rdata     <= 16'h0000;
      o_lnk_rvalid    <= 1'b0;
      o_lnk_busy      <= 1'b0;
    end else begin
      lnk_wack_s1_reg <= sys_wack_reg;
      lnk_wack_s2_reg <= lnk_wack_s1_reg;
      lnk_rack_s1_reg <= sys_rack_reg;
      lnk_rack_s2_reg <= lnk_rack_s1_reg;
      lnk_rack_s3_reg <= lnk_rack_s2_reg;
      o_lnk_rvalid    <= lnk_rdone;
      o_lnk_busy      <= lnk_take || (lnk_pending && !lnk_rdone);
      if (lnk_rdone) begin
        o_lnk_rdata <= sys_rdata_reg;
      end
    end
  end

  // ***************************************************************
  // Core domain: synchronisers
  // ***************************************************************
  logic [2:0]  sys_wtog_sync_reg, sys_rtog_sync_reg;
  logic [1:0]  rpin_sync_reg;
  logic        rpin_last_reg;
  logic [3:0]  strap_s1_reg, strap_s2_reg;
  logic [10:0] freq_s1_reg, freq_s2_reg;

  // Two flops on every foreign input; third stage only for edge detection
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_wtog_sync_reg <= 3'h0;
      sys_rtog_sync_reg <= 3'h0;
      rpin_sync_reg     <= 2'h3;
      rpin_last_reg     <= 1'b1;
      strap_s1_reg      <= 4'h0;
      strap_s2_reg      <= 4'h0;
      freq_s1_reg       <= 11'h000;
      freq_s2_reg       <= 11'h000;
    end else begin
      sys_wtog_sync_reg <= {sys_wtog_sync_reg[1:0], lnk_wtog_reg};
      sys_rtog_sync_reg <= {sys_rtog_sync_reg[1:0], lnk_rtog_reg};
      rpin_sync_reg     <= {rpin_sync_reg[0], i_setpoint_reset_pin_n};
      rpin_last_reg     <= rpin_sync_reg[1];
      strap_s1_reg      <= i_strap_code;
      strap_s2_reg      <= strap_s1_reg;
      freq_s1_reg       <= i_freq_req_khz;
      freq_s2_reg       <= freq_s1_reg;
    end
  end

  wire wr_fire  = sys_wtog_sync_reg[2] != sys_wtog_sync_reg[1];
  wire rd_fire  = sys_rtog_sync_reg[2] != sys_rtog_sync_reg[1];
  wire rpin_low = !rpin_sync_reg[1];
  wire rpin_evt = rpin_last_reg && !rpin_sync_reg[1];
  wire [7:0]  w_cmd  = lnk_req_reg.cmd;
  wire [15:0] w_data = lnk_req_reg.data;

  // ***************************************************************
  // Boot strap decoder
  // ***************************************************************
  ovc_pkg::ovc_strap_st_t strap_st_reg;
  logic [15:0] gap_cnt_reg;
  logic [3:0]  strap_last_reg;
  logic [2:0]  match_cnt_reg;
  logic [4:0]  tries_reg;
  logic        strap_used_reg;
  logic        strap_fault_reg;
  logic [11:0] boot_reg;

  wire [11:0] strap_val =
    (strap_s2_reg == 4'h0) ? `OVC_BOOT_0 : (strap_s2_reg == 4'h1) ? `OVC_BOOT_1 :
    (strap_s2_reg == 4'h2) ? `OVC_BOOT_2 : (strap_s2_reg == 4'h3) ? `OVC_BOOT_3 :
    (strap_s2_reg == 4'h4) ? `OVC_BOOT_4 : (strap_s2_reg == 4'h5) ? `OVC_BOOT_5 :
    (strap_s2_reg == 4'h6) ? `OVC_BOOT_6 : (strap_s2_reg == 4'h7) ? `OVC_BOOT_7 :
    `OVC_BOOT_8;
  wire strap_legal = (strap_s2_reg <= `OVC_STRAP_HIGH);
  wire strap_same  = strap_legal && (strap_s2_reg == strap_last_reg);
  wire gap_end     = (gap_cnt_reg == 16'h0000);

  // Sample after each gap; four equal legal readings in a row resolve the strap
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_st_reg    <= ovc_pkg::ST_SAMPLE;
      gap_cnt_reg     <= GAP_RLD;
      strap_last_reg  <= 4'hf;
      match_cnt_reg   <= 3'h0;
      tries_reg       <= 5'h00;
      strap_used_reg  <= 1'b0;
      strap_fault_reg <= 1'b0;
      boot_reg        <= 12'h000;
    end else begin
      unique case (strap_st_reg)
        ovc_pkg::ST_SAMPLE: begin
          gap_cnt_reg <= gap_end ? GAP_RLD : gap_cnt_reg - 16'h0001;
          if (gap_end) begin
            strap_last_reg <= strap_s2_reg;
            match_cnt_reg  <= strap_same ? match_cnt_reg + 3'h1 : {2'b00, strap_legal};
            tries_reg      <= tries_reg + 5'h01;
            strap_st_reg   <= ovc_pkg::ST_RESOLVE;
          end
        end
        ovc_pkg::ST_RESOLVE: begin
          if (match_cnt_reg == `OVC_STRAP_MATCH) begin
            strap_used_reg <= (strap_last_reg != `OVC_STRAP_HIGH);
            boot_reg       <= (strap_last_reg == `OVC_STRAP_HIGH) ? i_nvm_setpoint
                                                                   : strap_val;
            strap_st_reg   <= ovc_pkg::ST_DONE;
          end else if (tries_reg == `OVC_STRAP_TRIES) begin
            strap_fault_reg <= 1'b1;
            boot_reg        <= i_nvm_setpoint;
            strap_st_reg    <= ovc_pkg::ST_DONE;
          end else begin
            strap_st_reg <= ovc_pkg::ST_SAMPLE;
          end
        end
        ovc_pkg::ST_DONE: begin
          strap_st_reg <= ovc_pkg::ST_DONE;
        end
        // Unused code: restart the decode rather than lock up
        default: begin
          strap_st_reg <= ovc_pkg::ST_SAMPLE;
        end
      endcase
    end
  end

  wire boot_done = (strap_st_reg == ovc_pkg::ST_DONE);
  wire boot_evt  = (strap_st_reg == ovc_pkg::ST_RESOLVE) &&
                   ((match_cnt_reg == `OVC_STRAP_MATCH) || (tries_reg == `OVC_STRAP_TRIES));

  // ***************************************************************
  // Register file and set-point command
  // ***************************************************************
  logic [15:0] vmax_reg, vmin_reg, scale_reg, opt_reg;
  logic [7:0]  mhi_reg, mlo_reg, trim_reg, status_reg;
  logic [1:0]  oper_reg;
  logic [11:0] vcmd_reg;

  // Window check against the current scale, then min and max clamp
  wire [11:0] w_code   = w_data[11:0];
  wire        in_win   = (w_data[15:12] == 4'h0) && (w_code >= win_lo(scale_reg)) &&
                         (w_code <= win_hi(scale_reg));
  wire        over_max = {4'h0, w_code} > vmax_reg;
  wire        under_mn = {4'h0, w_code} < vmin_reg;
  wire [11:0] clamped  = over_max ? vmax_reg[11:0] : under_mn ? vmin_reg[11:0] : w_code;
  wire        scale_ok = (w_data == `OVC_SCL_ONE) ||
                         (!strap_used_reg && ((w_data == `OVC_SCL_HALF) ||
                                              (w_data == `OVC_SCL_QTR)));
  wire        vcmd_wr  = wr_fire && (w_cmd == `OVC_CMD_VCMD) && !rpin_low && in_win;
  wire        restore  = i_fault_restart && opt_reg[`OVC_OPT_RESTORE];

  // Configuration writes; ranged fields are clipped to their legal span
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vmax_reg  <= {4'h0, `OVC_W1_HI};
      vmin_reg  <= {4'h0, `OVC_W1_LO};
      scale_reg <= `OVC_SCL_ONE;
      opt_reg   <= 16'h0000;
      mhi_reg   <= 8'h00;
      mlo_reg   <= 8'h00;
      trim_reg  <= 8'h00;
      oper_reg  <= `OVC_OP_NONE;
    end else if (wr_fire) begin
      if (w_cmd == `OVC_CMD_VMAX) vmax_reg <= w_data;
      if (w_cmd == `OVC_CMD_VMIN) vmin_reg <= w_data;
      if (w_cmd == `OVC_CMD_SCALE && scale_ok) scale_reg <= w_data;
      if (w_cmd == `OVC_CMD_OPT) opt_reg <= w_data;
      if (w_cmd == `OVC_CMD_MHI) mhi_reg <= clip8(w_data[7:0], `OVC_MRG_MIN, `OVC_MRG_MAX);
      if (w_cmd == `OVC_CMD_MLO) mlo_reg <= clip8(w_data[7:0], `OVC_MRG_MIN, `OVC_MRG_MAX);
      if (w_cmd == `OVC_CMD_TRIM) trim_reg <= clip8(w_data[7:0], `OVC_TRIM_MIN,
                                                    `OVC_TRIM_MAX);
      if (w_cmd == `OVC_CMD_OPER && w_data[1:0] != 2'h3) oper_reg <= w_data[1:0];
    end
  end

  // Set point: boot load, pin reset and fault restore outrank a bus write
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vcmd_reg <= 12'h000;
    end else if (boot_evt) begin
      if (match_cnt_reg == `OVC_STRAP_MATCH) begin
        vcmd_reg <= (strap_last_reg == `OVC_STRAP_HIGH) ? i_nvm_setpoint : strap_val;
      end else begin
        vcmd_reg <= i_nvm_setpoint;
      end
    end else if (boot_done && rpin_low) begin
      vcmd_reg <= boot_reg;
    end else if (boot_done && restore) begin
      vcmd_reg <= boot_reg;
    end else if (vcmd_wr) begin
      vcmd_reg <= clamped;
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  wire clr_fire = wr_fire && (w_cmd == `OVC_CMD_CLR);
  logic [7:0] status_set;
  always_comb begin
    status_set = 8'h00;
    status_set[`OVC_ST_MAX]   = vcmd_wr && over_max;
    status_set[`OVC_ST_MIN]   = vcmd_wr && under_mn && !over_max;
    status_set[`OVC_ST_RSTV]  = boot_done && rpin_evt;
    status_set[`OVC_ST_STRAP] = boot_evt && (match_cnt_reg != `OVC_STRAP_MATCH);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= (clr_fire ? 8'h00 : status_reg) | status_set;
    end
  end

  // Read mux and acknowledges back to the link
  wire [15:0] rd_mux =
    (w_cmd == `OVC_CMD_VMAX)   ? vmax_reg  : (w_cmd == `OVC_CMD_VMIN)  ? vmin_reg :
    (w_cmd == `OVC_CMD_SCALE)  ? scale_reg : (w_cmd == `OVC_CMD_OPT)   ? opt_reg :
    (w_cmd == `OVC_CMD_STATUS) ? {8'h00, status_reg} :
    (w_cmd == `OVC_CMD_MHI)    ? {8'h00, mhi_reg}  : (w_cmd == `OVC_CMD_MLO) ? {8'h00, mlo_reg} :
    (w_cmd == `OVC_CMD_TRIM)   ? {8'h00, trim_reg} :
    (w_cmd == `OVC_CMD_OPER)   ? {14'h0000, oper_reg} :
    (w_cmd == `OVC_CMD_VCMD)   ? {4'h0, vcmd_reg}  : 16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_wack_reg  <= 1'b0;
      sys_rack_reg  <= 1'b0;
      sys_rdata_reg <= 16'h0000;
    end else begin
      if (wr_fire) sys_wack_reg <= ~sys_wack_reg;
      if (rd_fire) begin
        sys_rdata_reg <= rd_mux;
        sys_rack_reg  <= ~sys_rack_reg;
      end
    end
  end

  // ***************************************************************
  // Reference composition and slewing
  // ***************************************************************
  wire signed [13:0] scaled = (scale_reg == `OVC_SCL_HALF) ? 14'(vcmd_reg >> 1) :
                              (scale_reg == `OVC_SCL_QTR)  ? 14'(vcmd_reg >> 2) :
                              14'(vcmd_reg);
  wire signed [7:0]  margin = (oper_reg == `OVC_OP_HIGH) ? mhi_reg :
                              (oper_reg == `OVC_OP_LOW)  ? mlo_reg : 8'sh00;
  wire signed [13:0] ref_sum = scaled + 14'(signed'(trim_reg)) + 14'(margin);
  // One code is 1.953 mV; saturate at the converter span
  wire signed [13:0] ref_sat = (ref_sum < `OVC_REF_LO) ? `OVC_REF_LO :
                               (ref_sum > `OVC_REF_HI) ? `OVC_REF_HI : ref_sum;
  wire [11:0] ref_tgt = ref_sat[11:0];

  logic [15:0] slew_cnt_reg;
  wire slew_tick = (slew_cnt_reg == 16'h0000);

  // Step one code per slew period; a pin reset cuts a wait longer than RST_KICK cycles to RST_KICK to meet the response time
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slew_cnt_reg <= SLEW_RLD;
      o_ref_code   <= `OVC_W1_LO;
    end else begin
      if (rpin_evt && slew_cnt_reg > RST_KICK) begin
        slew_cnt_reg <= RST_KICK;
      end else begin
        slew_cnt_reg <= slew_tick ? SLEW_RLD : slew_cnt_reg - 16'h0001;
      end
      if (slew_tick && boot_done && o_ref_code < ref_tgt) o_ref_code <= o_ref_code + 12'h001;
      if (slew_tick && boot_done && o_ref_code > ref_tgt) o_ref_code <= o_ref_code - 12'h001;
    end
  end

  // ***************************************************************
  // Enable, alert and frequency outputs
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_master_en   <= 1'b0;
      o_alert_o     <= 1'b0;
      o_alert_oe    <= 1'b0;
      o_boot_done   <= 1'b0;
      o_sw_freq_khz <= `OVC_FSW_MIN;
    end else begin
      o_master_en   <= boot_done && (!strap_fault_reg || opt_reg[`OVC_OPT_RUN]);
      o_alert_oe    <= status_reg[`OVC_ST_STRAP];
      o_boot_done   <= boot_done;
      o_sw_freq_khz <= (freq_s2_reg < `OVC_FSW_MIN) ? `OVC_FSW_MIN :
                       (freq_s2_reg > `OVC_FSW_MAX) ? `OVC_FSW_MAX : freq_s2_reg;
    end
  end

endmodule

// ---- ovc_regs_map.svh ----
// Register offsets, field positions, reset values and timing figures of the set-point block
`ifndef OVC_REGS_MAP_SVH
`define OVC_REGS_MAP_SVH

// Command codes on the link
`define OVC_CMD_VMAX      8'h24
`define OVC_CMD_VMIN      8'h28
`define OVC_CMD_SCALE     8'h29
`define OVC_CMD_STATUS    8'h80
`define OVC_CMD_MHI       8'hd5
`define OVC_CMD_MLO       8'hd6
`define OVC_CMD_OPT       8'he5
`define OVC_CMD_VCMD      8'hc0
`define OVC_CMD_TRIM      8'hc1
`define OVC_CMD_OPER      8'hc2
`define OVC_CMD_CLR       8'hc3

// Loop scale encodings (quarter units)
`define OVC_SCL_ONE       16'h0004
`define OVC_SCL_HALF      16'h0002
`define OVC_SCL_QTR       16'h0001

// Set-point windows per scale, 1.953 mV codes
`define OVC_W1_LO         12'h0b3
`define OVC_W1_HI         12'h34d
`define OVC_W2_LO         12'h166
`define OVC_W2_HI         12'h69a
`define OVC_W4_LO         12'h2cc
`define OVC_W4_HI         12'hb00

// Reference converter span, 350 mV to 1650 mV
`define OVC_REF_LO        14'sh00b3
`define OVC_REF_HI        14'sh034d

// Trim and margin ranges in steps
`define OVC_TRIM_MIN      8'shc0
`define OVC_TRIM_MAX      8'sh3f
`define OVC_MRG_MIN       8'shc0
`define OVC_MRG_MAX       8'sh1f

// Boot set points, 0.70 V to 1.10 V in 50 mV steps
`define OVC_BOOT_0        12'h166
`define OVC_BOOT_1        12'h180
`define OVC_BOOT_2        12'h19a
`define OVC_BOOT_3        12'h1b3
`define OVC_BOOT_4        12'h1cd
`define OVC_BOOT_5        12'h1e6
`define OVC_BOOT_6        12'h200
`define OVC_BOOT_7        12'h21a
`define OVC_BOOT_8        12'h233
`define OVC_STRAP_HIGH    4'h9
`define OVC_STRAP_MATCH   3'h4
`define OVC_STRAP_TRIES   5'h10

// Status and option bit positions
`define OVC_ST_MAX        0
`define OVC_ST_MIN        1
`define OVC_ST_RSTV       3
`define OVC_ST_STRAP      4
`define OVC_OPT_RESTORE   0
`define OVC_OPT_RUN       1

// Operation margin selections
`define OVC_OP_NONE       2'h0
`define OVC_OP_HIGH       2'h1
`define OVC_OP_LOW        2'h2

// Switching frequency span in kHz
`define OVC_FSW_MIN       11'h0c8
`define OVC_FSW_MAX       11'h3e8

// Timing
`define OVC_CLK_NS        25
`define OVC_RST_RESP_NS   2000

`endif

// ---- ovc_pkg.sv ----
// Types shared by the set-point block
package ovc_pkg;

  // One link request: command code and data word
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] data;
  } ovc_req_t;

  // Boot strap decoder states
  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_RESOLVE,
    ST_DONE
  } ovc_strap_st_t;

endpackage

// ---- ovc_setpoint_ctrl_asserts.sv ----
// Concurrent checks on the core-side ports of the set-point block
`timescale 1ns/1ps
module ovc_setpoint_ctrl_asserts (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic [10:0] i_freq_req_khz,
  input wire logic [11:0] o_ref_code,
  input wire logic        o_master_en,
  input wire logic        o_alert_o,
  input wire logic        o_alert_oe,
  input wire logic        o_boot_done,
  input wire logic [10:0] o_sw_freq_khz
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Expected frequency once a request has been steady past the synchroniser
  logic [10:0] fq_exp;
  assign fq_exp = (i_freq_req_khz < 11'h0c8) ? 11'h0c8 :
                  (i_freq_req_khz > 11'h3e8) ? 11'h3e8 : i_freq_req_khz;
  ref_span_a: assert property (o_ref_code >= 12'h0b3 && o_ref_code <= 12'h34d)
    else $error("reference outside converter span");
  ref_step_a: assert property (o_ref_code != $past(o_ref_code) |->
    (o_ref_code - $past(o_ref_code) == 12'h001 || $past(o_ref_code) - o_ref_code == 12'h001))
    else $error("reference moved by more than one code");
  boot_ref_a: assert property (!o_boot_done |-> o_ref_code == 12'h0b3)
    else $error("reference moved before boot decode");
  boot_hold_a: assert property (o_boot_done |=> o_boot_done)
    else $error("boot done dropped");
  en_boot_a: assert property (o_master_en |-> o_boot_done)
    else $error("converter enabled before boot decode");
  alert_boot_a: assert property (o_alert_oe |-> o_boot_done)
    else $error("alert before strap decode ended");
  alert_low_a: assert property (o_alert_o == 1'b0)
    else $error("alert line driven high");
  freq_track_a: assert property ($stable(i_freq_req_khz)[*5] |-> o_sw_freq_khz == fq_exp)
    else $error("switching frequency not clamped request");
  // Main scenarios reached
  boot_c: cover property ($rose(o_boot_done));
  alert_c: cover property ($rose(o_alert_oe));
  clamp_c: cover property (i_freq_req_khz > 11'h3e8 && o_sw_freq_khz == 11'h3e8);
endmodule
bind ovc_setpoint_ctrl ovc_setpoint_ctrl_asserts u_chk (.*);

// ---- ovc_host_model.sv ----
// Link host model: makes the link clock and issues one request at a time
`timescale 1ns/1ps
module ovc_host_model (
  input  wire logic        i_lnk_busy,
  input  wire logic        i_lnk_rvalid,
  input  wire logic [15:0] i_lnk_rdata,
  output logic             o_lnk_clk,
  output logic             o_lnk_wr,
  output logic             o_lnk_rd,
  output ovc_pkg::ovc_req_t o_lnk_req
);
  logic run = 1'b0;
  // Clock parks low between transfers; odd offset keeps it out of phase with the core
  initial begin
    o_lnk_clk = 1'b0;
    o_lnk_wr = 1'b0;
    o_lnk_rd = 1'b0;
    o_lnk_req = '0;
    #7;
    forever #16 o_lnk_clk = run & ~o_lnk_clk;
  end
  // Request stands one edge, then wait for busy to rise and fall (bounded)
  task automatic xfer(input logic is_rd, input ovc_pkg::ovc_req_t r, output logic [15:0] q);
    logic seen;
    seen = 1'b0;
    q = 16'h0000;
    run = 1'b1;
    repeat (2) @(posedge o_lnk_clk);
    o_lnk_wr <= !is_rd;
    o_lnk_rd <= is_rd;
    o_lnk_req <= r;
    @(posedge o_lnk_clk);
    o_lnk_wr <= 1'b0;
    o_lnk_rd <= 1'b0;
    o_lnk_req <= ~r; // Released lines show the inverse, not the last value
    for (int n = 0; n < 40 && !(seen && !i_lnk_busy); n++) begin
      @(posedge o_lnk_clk);
      if (i_lnk_rvalid) q = i_lnk_rdata;
      seen |= i_lnk_busy;
    end
    @(posedge o_lnk_clk);
    run = 1'b0;
  endtask
endmodule

// ---- ovc_setpoint_ctrl_tb.sv ----
// Self-checking bench for the set-point block
`timescale 1ns/1ps
module ovc_setpoint_ctrl_tb;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              pin_n = 1'b1;
  logic              frst = 1'b0;
  logic [3:0]        strap = 4'h2;
  logic [10:0]       fq = 11'h7ff;
  logic [15:0]       q, rdat;
  logic              lclk, wr, rd, rv, busy, men, ao, aoe, bd;
  logic [11:0]       refc;
  logic [10:0]       fsw;
  ovc_pkg::ovc_req_t req;
  int                n_errors = 0;
  int                checked = 0;
  int                cyc = 0;
  // Command, data and settled reference; ignored writes leave it unchanged
  logic [35:0]       steps [20] = '{36'hc00200200, 36'hc000b2200, 36'h240300200,
    36'hc00320300, 36'h280100300, 36'hc000c0100, 36'hc00200200, 36'hc1003f23f,
    36'hc100801c0, 36'hc10000200, 36'hd5007f200, 36'hd600c0200, 36'hc2000121f,
    36'hc200021c0, 36'hc200031c0, 36'hc20000200, 36'h2800b3200, 36'hc000b30b3,
    36'hc100c00b3, 36'hc100000b3};
  initial forever #12.5 clk = ~clk;
  ovc_setpoint_ctrl #(.SLEW_CYC(2), .STRAP_GAP(4)) u_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_lnk_clk(lclk), .i_lnk_wr(wr), .i_lnk_rd(rd), .i_lnk_cmd(req.cmd),
    .i_lnk_wdata(req.data), .i_strap_code(strap), .i_setpoint_reset_pin_n(pin_n),
    .i_nvm_setpoint(12'h1cd), .i_fault_restart(frst), .i_freq_req_khz(fq),
    .o_lnk_rdata(rdat), .o_lnk_rvalid(rv), .o_lnk_busy(busy), .o_ref_code(refc),
    .o_master_en(men), .o_alert_o(ao), .o_alert_oe(aoe), .o_boot_done(bd),
    .o_sw_freq_khz(fsw));
  ovc_host_model u_host (.i_lnk_busy(busy), .i_lnk_rvalid(rv), .i_lnk_rdata(rdat),
    .o_lnk_clk(lclk), .o_lnk_wr(wr), .o_lnk_rd(rd), .o_lnk_req(req));
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b0, {c, d}, q);
  endtask
  task automatic rd_reg(input logic [7:0] c);
    u_host.xfer(1'b1, {c, 16'h0000}, q);
  endtask
  // Bounded wait; slewing takes two core cycles per code
  task automatic settle(input logic [11:0] e);
    for (int i = 0; i < 3000 && refc !== e; i++) @(posedge clk);
    chk("ref", {4'h0, refc}, {4'h0, e});
  endtask
  // Reset stands for power-up; link clock runs so both domains see it
  task automatic boot(input logic [3:0] s);
    @(posedge clk);
    strap <= s;
    rst_b <= 1'b0;
    u_host.run = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    u_host.run = 1'b0;
    for (int i = 0; i < 400 && bd !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic t_boot;
    boot(4'h2);
    chk("done", bd, 1'b1);
    settle(12'h19a);
    chk("en", men, 1'b1);
    rd_reg(8'h29);
    chk("scale", q, 16'h0004);
    wr_reg(8'h29, 16'h0002);
    rd_reg(8'h29);
    chk("scale", q, 16'h0004);
    $display("test boot done");
  endtask
  task automatic t_steps;
    foreach (steps[i]) begin
      wr_reg(steps[i][35:28], steps[i][27:12]);
      settle(steps[i][11:0]);
    end
    rd_reg(8'h80);
    chk("clamps", q[1:0], 2'h3);
    $display("test steps done");
  endtask
  task automatic t_pin;
    wr_reg(8'hc0, 16'h0250);
    settle(12'h250);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (80) @(posedge clk);
    chk("moving", refc < 12'h250, 1'b1);
    wr_reg(8'hc0, 16'h0300);
    settle(12'h19a);
    rd_reg(8'h80);
    chk("reset flag", q[3], 1'b1);
    @(posedge clk);
    pin_n <= 1'b1;
    wr_reg(8'he5, 16'h0001);
    wr_reg(8'hc0, 16'h0250);
    settle(12'h250);
    @(posedge clk);
    frst <= 1'b1;
    @(posedge clk);
    frst <= 1'b0;
    settle(12'h19a);
    $display("test pin done");
  endtask
  task automatic t_freq;
    fq <= 11'h064;
    repeat (8) @(posedge clk);
    chk("fsw", fsw, 11'h0c8);
    fq <= 11'h1f4;
    repeat (8) @(posedge clk);
    chk("fsw", fsw, 11'h1f4);
    $display("test freq done");
  endtask
  task automatic t_fault;
    boot(4'hf);
    chk("alert", aoe, 1'b1);
    chk("en", men, 1'b0);
    settle(12'h1cd);
    rd_reg(8'h80);
    chk("strap flag", q[4], 1'b1);
    boot(4'h9);
    settle(12'h1cd);
    wr_reg(8'hc0, 16'h0250);
    boot(4'h2);
    settle(12'h19a);
    $display("test fault done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_boot;
    t_steps;
    t_pin;
    t_freq;
    t_fault;
    finish_test;
  end
endmodule
